/* rshift_pkg.sv */
// constants and types shared by the accumulator right shifter
package rshift_pkg;
    // --------------------------------------------------------------
    // datapath widths
    // --------------------------------------------------------------
    localparam int ACCUM_W = 24;
    localparam int COUNT_W = 5;
    localparam int PC_W    = 15;

    // --------------------------------------------------------------
    // field positions and values
    // --------------------------------------------------------------
    localparam int ACCUM_MSB = 23;
    localparam int ACCUM_LSB = 0;
    localparam logic [COUNT_W-1:0] COUNT_TERMINAL = 5'h1f;
    localparam logic [COUNT_W-1:0] COUNT_RESET    = 5'h1f;
    localparam logic [COUNT_W-1:0] COUNT_STEP     = 5'h01;
    localparam logic [COUNT_W-1:0] MAX_SHIFTS     = 5'h18;
    localparam logic [PC_W-1:0]    PC_STEP        = 15'h0001;
    localparam logic [PC_W-1:0]    PC_RESET       = 15'h0000;
    localparam logic [ACCUM_W-1:0] ACCUM_RESET    = 24'h000000;

    // --------------------------------------------------------------
    // sequencer states
    // --------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_DONE  = 2'b10
    } shift_state_t;
endpackage : rshift_pkg

/* shift_count_reg.sv */
// five-bit shift counter with load, increment and terminal flag
`timescale 1ns/1ps
module shift_count_reg #(
    parameter int WIDTH = rshift_pkg::COUNT_W
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rstn_i,
    input  wire logic             load_i,
    input  wire logic [WIDTH-1:0] load_value_i,
    input  wire logic             inc_i,
    output logic      [WIDTH-1:0] count_o,
    output logic                  terminal_o
);
    import rshift_pkg::*;

    // ----------------------------------------------------------
    // counter register
    // ----------------------------------------------------------
    // load wins over increment; rests at all ones
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count_o <= COUNT_RESET;
        end else if (load_i) begin
            count_o <= load_value_i;
        end else if (inc_i) begin
            count_o <= count_o + COUNT_STEP;
        end
    end

    // terminal when all ones
    assign terminal_o = (count_o == COUNT_TERMINAL);
endmodule : shift_count_reg

/* accumulator_right_shifter.sv */
// accumulator right shifter: rotate right and logical right shift
`timescale 1ns/1ps
module accumulator_right_shifter (
    input  wire logic                            clk_sys_i,
    input  wire logic                            rstn_i,
    input  wire logic                            state_four_i,
    input  wire logic                            rotate_right_op_i,
    input  wire logic [rshift_pkg::COUNT_W-1:0]  shift_count_i,
    input  wire logic                            group_one_decode_i,
    input  wire logic                            execute_timing_pulse_i,
    input  wire logic                            count_inc_qualifier_a_i,
    input  wire logic                            count_inc_qualifier_b_i,
    input  wire logic                            accum_load_i,
    input  wire logic [rshift_pkg::ACCUM_W-1:0]  accum_data_i,
    input  wire logic                            pc_load_i,
    input  wire logic [rshift_pkg::PC_W-1:0]     pc_data_i,
    input  wire logic                            flags_load_i,
    input  wire logic                            test_flag_i,
    input  wire logic                            overflow_flag_i,
    input  wire logic                            memory_protect_flag_i,
    output logic      [rshift_pkg::ACCUM_W-1:0]  accum_o,
    output logic      [rshift_pkg::COUNT_W-1:0]  shift_count_o,
    output logic      [rshift_pkg::PC_W-1:0]     pc_o,
    output logic                                 busy_o,
    output logic                                 done_o,
    output logic                                 adder_carry_ff_o,
    output logic                                 test_flag_o,
    output logic                                 overflow_flag_o,
    output logic                                 memory_protect_flag_o
);
    import rshift_pkg::*;

    // ----------------------------------------------------------
    // declarations
    // ----------------------------------------------------------
    shift_state_t       state;
    shift_state_t       next_state;
    logic               rotate_mode;
    logic               adder_a_gate_select;
    logic               adder_a_input;
    logic               adder_sum;
    logic               accum_shift_right_enable;
    logic               count_inc_enable;
    logic               shift_step;
    logic               shift_count_terminal;
    logic               count_load;
    logic [COUNT_W-1:0] clamped_count;
    logic [COUNT_W-1:0] count_load_value;
    logic [COUNT_W-1:0] count_value;
    logic [COUNT_W-1:0] shifts_done;
    logic [COUNT_W-1:0] requested_shifts;

    // ----------------------------------------------------------
    // shift counter
    // ----------------------------------------------------------
    // counts above 24 are clamped so no more than 24 shifts occur
    assign clamped_count = (shift_count_i > MAX_SHIFTS)
                         ? MAX_SHIFTS : shift_count_i;
    assign count_load_value = ~clamped_count;
    assign count_load = (state == ST_IDLE) && state_four_i;

    shift_count_reg #(
        .WIDTH (COUNT_W)
    ) u_count (
        .clk_sys_i    (clk_sys_i),
        .rstn_i       (rstn_i),
        .load_i       (count_load),
        .load_value_i (count_load_value),
        .inc_i        (shift_step),
        .count_o      (count_value),
        .terminal_o   (shift_count_terminal)
    );

    // ----------------------------------------------------------
    // shift and increment enables
    // ----------------------------------------------------------
    // shift only in shift state with decode and timing active
    assign accum_shift_right_enable = (state == ST_SHIFT)
                                    && group_one_decode_i
                                    && execute_timing_pulse_i
                                    && !shift_count_terminal;
    // increment only with both qualifiers while not terminal
    assign count_inc_enable = !shift_count_terminal
                            && count_inc_qualifier_a_i
                            && count_inc_qualifier_b_i;
    // shift and increment move together, one per step
    assign shift_step = accum_shift_right_enable
                      && count_inc_enable;

    // ----------------------------------------------------------
    // serial adder feed
    // ----------------------------------------------------------
    // bit 0 gated to the adder a input only for rotate
    assign adder_a_gate_select = rotate_mode;
    assign adder_a_input = accum_o[ACCUM_LSB]
                         && adder_a_gate_select;
    // b input disabled, carry held clear: sum equals a input
    assign adder_sum = adder_a_input ^ adder_carry_ff_o;

    // ----------------------------------------------------------
    // state sequencing
    // ----------------------------------------------------------
    // next state from start pulse and terminal count
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (state_four_i) begin
                    next_state = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (shift_count_terminal) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // operation latched at the start pulse
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rotate_mode <= 1'b0;
        end else if (count_load) begin
            rotate_mode <= rotate_right_op_i;
        end
    end

    // ----------------------------------------------------------
    // accumulator
    // ----------------------------------------------------------
    // rotate feeds adder sum to bit 23, logical feeds zero
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            accum_o <= ACCUM_RESET;
        end else if (shift_step) begin
            accum_o <= {adder_sum, accum_o[ACCUM_MSB:1]};
        end else if (accum_load_i && (state == ST_IDLE)) begin
            accum_o <= accum_data_i;
        end
    end

    // ----------------------------------------------------------
    // adder carry
    // ----------------------------------------------------------
    // no summation takes place, carry kept clear
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            adder_carry_ff_o <= 1'b0;
        end else begin
            adder_carry_ff_o <= 1'b0;
        end
    end

    // ----------------------------------------------------------
    // program counter and flags
    // ----------------------------------------------------------
    // pc advances once when the instruction completes
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pc_o <= PC_RESET;
        end else if (state == ST_DONE) begin
            pc_o <= pc_o + PC_STEP;
        end else if (pc_load_i && (state == ST_IDLE)) begin
            pc_o <= pc_data_i;
        end
    end

    // flags only loadable while idle, untouched by the shift
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            test_flag_o           <= 1'b0;
            overflow_flag_o       <= 1'b0;
            memory_protect_flag_o <= 1'b0;
        end else if (flags_load_i && (state == ST_IDLE)) begin
            test_flag_o           <= test_flag_i;
            overflow_flag_o       <= overflow_flag_i;
            memory_protect_flag_o <= memory_protect_flag_i;
        end
    end

    // ----------------------------------------------------------
    // status outputs
    // ----------------------------------------------------------
    // busy from start to completion, done a one-cycle pulse
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            busy_o <= (next_state != ST_IDLE);
            done_o <= (state == ST_DONE);
        end
    end

    // registered copy of the counter
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            shift_count_o <= COUNT_RESET;
        end else begin
            shift_count_o <= count_value;
        end
    end

    // ----------------------------------------------------------
    // checking helpers
    // ----------------------------------------------------------
    // shifts performed in the current instruction
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            shifts_done <= '0;
        end else if (count_load) begin
            shifts_done <= '0;
        end else if (shift_step) begin
            shifts_done <= shifts_done + COUNT_STEP;
        end
    end

    // shift count asked for by the current instruction, after the cap
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            requested_shifts <= '0;
        end else if (count_load) begin
            requested_shifts <= clamped_count;
        end
    end

    // ----------------------------------------------------------
    // assertions
    // ----------------------------------------------------------
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rstn_i);

    chk_rotate_wrap: assert property (
        shift_step && rotate_mode |=>
        accum_o == {$past(accum_o[ACCUM_LSB]), $past(accum_o[ACCUM_MSB:1])})
        else $error("rotate did not move bit 0 into bit 23");

    chk_max_shifts: assert property (
        shifts_done <= MAX_SHIFTS)
        else $error("more than 24 shifts in one instruction");

    chk_count_load: assert property (
        count_load && (shift_count_i <= MAX_SHIFTS) |=>
        count_value == ~$past(shift_count_i))
        else $error("counter not loaded with complement of count");

    chk_count_inc: assert property (
        shift_step |=> count_value == $past(count_value) + COUNT_STEP)
        else $error("counter did not advance with the shift");

    chk_stop_terminal: assert property (
        (state == ST_SHIFT) && shift_count_terminal |->
        !shift_step ##1 (state == ST_DONE) && $stable(accum_o))
        else $error("shift continued past terminal count");

    chk_exact_shifts: assert property (
        (state == ST_DONE) |-> (shifts_done == requested_shifts)
        && (count_value == COUNT_TERMINAL))
        else $error("shift total or final counter wrong");

    chk_adder_feed: assert property (
        shift_step && rotate_mode |-> adder_sum == accum_o[ACCUM_LSB])
        else $error("adder sum does not follow bit 0");

    chk_logical_fill: assert property (
        shift_step && !rotate_mode |=> accum_o[ACCUM_MSB] == 1'b0)
        else $error("logical shift did not insert zero");

    chk_logical_drop: assert property (
        shift_step && !rotate_mode |=>
        accum_o[ACCUM_MSB-1:0] == $past(accum_o[ACCUM_MSB:1]))
        else $error("logical shift moved bits wrongly");

    chk_carry_clear: assert property (
        busy_o |-> !adder_carry_ff_o)
        else $error("adder carry set during shift");

    chk_shift_gate: assert property (
        $changed(accum_o) && ($past(state) != ST_IDLE) |->
        $past(group_one_decode_i && execute_timing_pulse_i
        && !shift_count_terminal))
        else $error("shift enable without its qualifiers");

    chk_inc_gate: assert property (
        $changed(count_value) && !$past(count_load) |->
        $past(count_inc_qualifier_a_i && count_inc_qualifier_b_i
        && !shift_count_terminal))
        else $error("increment without its qualifiers");

    chk_pc_advance: assert property (
        (state == ST_DONE) |=> pc_o == $past(pc_o) + PC_STEP
        && $stable(test_flag_o) && $stable(overflow_flag_o)
        && $stable(memory_protect_flag_o) && done_o)
        else $error("completion did not advance pc alone");

    cov_rotate_full: cover property (
        (state == ST_DONE) && rotate_mode && (shifts_done == MAX_SHIFTS));
    cov_logical_some: cover property (
        (state == ST_DONE) && !rotate_mode && (shifts_done != '0));
    cov_zero_count: cover property (
        count_load && (shift_count_i == '0));
    cov_clamped: cover property (
        count_load && (shift_count_i > MAX_SHIFTS));
endmodule : accumulator_right_shifter

/* instr_sequencer_model.sv */
// behavioural model of the instruction decode and timing sequencer
`timescale 1ns/1ps
module instr_sequencer_model (
    input  wire logic       clk_sys_i,
    input  wire logic       rstn_i,
    input  wire logic       go_i,
    input  wire logic       rotate_i,
    input  wire logic [4:0] count_i,
    input  wire logic       slow_i,
    output logic            state_four_o,
    output logic            rotate_right_op_o,
    output logic [4:0]      shift_count_o,
    output logic            group_one_decode_o,
    output logic            execute_timing_pulse_o,
    output logic            count_inc_qualifier_a_o,
    output logic            count_inc_qualifier_b_o
);
    integer     seed = 32'h1c0ffee5;
    logic [7:0] r;
    // ----------------------------------------------------------
    // start pulse and instruction fields, one pulse per request
    // ----------------------------------------------------------
    always @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_four_o      <= 1'b0;
            rotate_right_op_o <= 1'b0;
            shift_count_o     <= 5'h00;
        end else begin
            state_four_o <= go_i && !state_four_o;
            if (go_i) begin
                rotate_right_op_o <= rotate_i;
                shift_count_o     <= count_i;
            end
        end
    end
    // ----------------------------------------------------------
    // timing qualifiers: steady when prompt, gappy when slow
    // ----------------------------------------------------------
    always @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {group_one_decode_o, execute_timing_pulse_o} <= 2'b00;
            {count_inc_qualifier_a_o, count_inc_qualifier_b_o} <= 2'b00;
        end else begin
            r = slow_i ? 8'($random(seed)) : 8'hff;
            group_one_decode_o      <= |r[1:0];
            execute_timing_pulse_o  <= |r[3:2];
            count_inc_qualifier_a_o <= |r[5:4];
            count_inc_qualifier_b_o <= |r[7:6];
        end
    end
endmodule : instr_sequencer_model

/* tb_accumulator_right_shifter.sv */
// self-checking testbench for the accumulator right shifter
`timescale 1ns/1ps
module tb_accumulator_right_shifter;
    import rshift_pkg::*;
    logic clk_sys_i = 1'b0, rstn_i = 1'b0, go = 1'b0, rot = 1'b0, slow = 1'b0;
    logic [4:0] zv = 5'h00;
    logic sf, rop, grp, tim, qa, qb, busy_o, done_o, carry, tf, of, mp;
    logic [4:0] cnt, cnt_o;
    logic accum_load = 1'b0, pc_load = 1'b0, flags_load = 1'b0;
    logic [23:0] accum_data = 24'h000000, accum_o;
    logic [14:0] pc_data = 15'h0000, pc_o;
    logic [2:0]  flags_data = 3'h0;
    integer seed = 32'he5ef8f14;
    int failures = 0, check_count = 0;

    always #12.5 clk_sys_i = ~clk_sys_i;

    instr_sequencer_model seq_u (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .go_i(go),
        .rotate_i(rot), .count_i(zv), .slow_i(slow), .state_four_o(sf),
        .rotate_right_op_o(rop), .shift_count_o(cnt), .group_one_decode_o(grp),
        .execute_timing_pulse_o(tim), .count_inc_qualifier_a_o(qa),
        .count_inc_qualifier_b_o(qb));

    accumulator_right_shifter dut_u (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .state_four_i(sf), .rotate_right_op_i(rop), .shift_count_i(cnt),
        .group_one_decode_i(grp), .execute_timing_pulse_i(tim),
        .count_inc_qualifier_a_i(qa), .count_inc_qualifier_b_i(qb),
        .accum_load_i(accum_load), .accum_data_i(accum_data), .pc_load_i(pc_load),
        .pc_data_i(pc_data), .flags_load_i(flags_load), .test_flag_i(flags_data[2]),
        .overflow_flag_i(flags_data[1]), .memory_protect_flag_i(flags_data[0]),
        .accum_o(accum_o), .shift_count_o(cnt_o), .pc_o(pc_o), .busy_o(busy_o),
        .done_o(done_o), .adder_carry_ff_o(carry), .test_flag_o(tf),
        .overflow_flag_o(of), .memory_protect_flag_o(mp));

    // ------------------------------------------------------------
    // comparison, verdict and watchdog
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    initial begin
        #(25.0 * 40000);
        failures++;
        finish_test();
    end

    // carry stays clear for the whole of every operation
    always @(posedge clk_sys_i) begin
        if (rstn_i && busy_o) check("carry", 32'(carry), 32'h0);
    end

    // ------------------------------------------------------------
    // expectation: shift n places, n capped at 24
    // ------------------------------------------------------------
    function automatic logic [23:0] exp_shift(logic [23:0] a, logic r, logic [4:0] z);
        int n;
        n = (z > 5'd24) ? 24 : int'(z);
        for (int i = 0; i < n; i++) a = r ? {a[0], a[23:1]} : {1'b0, a[23:1]};
        return a;
    endfunction : exp_shift

    task automatic load_all(input logic [23:0] a, input logic [14:0] p, input logic [2:0] f);
        accum_data <= a;
        pc_data    <= p;
        flags_data <= f;
        {accum_load, pc_load, flags_load} <= 3'b111;
        @(posedge clk_sys_i);
        {accum_load, pc_load, flags_load} <= 3'b000;
        @(posedge clk_sys_i);
    endtask : load_all

    // one instruction; meddle=1 tries a load and a start while busy
    task automatic run_op(input logic r, input logic [4:0] z, input logic s, input logic meddle);
        logic [23:0] a0;
        logic [14:0] p0;
        logic [2:0]  f0;
        int          nb, n;
        a0 = accum_o;
        p0 = pc_o;
        f0 = {tf, of, mp};
        nb = 0;
        n  = (z > 5'd24) ? 24 : int'(z);
        rot  <= r;
        zv   <= z;
        slow <= s;
        go   <= 1'b1;
        @(posedge clk_sys_i);
        go <= 1'b0;
        for (int i = 0; i < 400; i++) begin
            @(posedge clk_sys_i);
            #1;
            if (busy_o === 1'b1) nb++;
            if (meddle && nb == 2) begin
                @(posedge clk_sys_i);
                accum_data <= ~a0;
                accum_load <= 1'b1;
                rot        <= ~r;
                zv         <= 5'h03;
                go         <= 1'b1;
                @(posedge clk_sys_i);
                {accum_load, go} <= 2'b00;
                #1;
                nb += 2;
            end
            if (done_o === 1'b1) break;
        end
        check("done", 32'(done_o), 32'h1);
        check("accum", 32'(accum_o), 32'(exp_shift(a0, r, z)));
        if (!r) check("fill", 32'(accum_o[23]), 32'(z == 0 ? a0[23] : 1'b0));
        check("count", 32'(cnt_o), 32'(COUNT_TERMINAL));
        check("pc", 32'(pc_o), 32'(15'(p0 + 15'h0001)));
        check("flags", 32'({tf, of, mp}), 32'(f0));
        if (!s) check("busy span", 32'(nb), 32'(n + 2));
        @(posedge clk_sys_i);
        check("idle", 32'(busy_o), 32'h0);
        $display("test op r=%0d z=%0d slow=%0d done", r, z, s);
    endtask : run_op

    task automatic check_reset();
        check("rst accum", 32'(accum_o), 32'(ACCUM_RESET));
        check("rst count", 32'(cnt_o), 32'(COUNT_RESET));
        check("rst pc", 32'(pc_o), 32'(PC_RESET));
        check("rst status", 32'({busy_o, done_o, carry, tf, of, mp}), 32'h0);
    endtask : check_reset

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [4:0] corner [8] = '{5'h00, 5'h01, 5'h02, 5'h17, 5'h18, 5'h19, 5'h1e, 5'h1f};
        repeat (19) @(posedge clk_sys_i);
        #1;
        check_reset();
        @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        @(posedge clk_sys_i);
        // corner counts for both operations, prompt sequencer
        for (int k = 0; k < 16; k++) begin
            load_all(24'h800001 ^ 24'($random(seed)), 15'h7ffe + 15'(k), 3'(k));
            run_op(k[0], corner[k / 2], 1'b0, 1'b0);
        end
        $display("test corners done");
        // random operands, gappy qualifiers stall the shift
        for (int k = 0; k < 12; k++) begin
            load_all(24'($random(seed)), 15'($random(seed)), 3'($random(seed)));
            run_op(1'($random(seed)), 5'($random(seed)), 1'b1, 1'b0);
        end
        $display("test random stalls done");
        // load and start while busy are ignored
        load_all(24'h5a3c96, 15'h0100, 3'h5);
        run_op(1'b1, 5'h0c, 1'b0, 1'b1);
        load_all(24'hf0f00f, 15'h0200, 3'h2);
        run_op(1'b0, 5'h0a, 1'b0, 1'b1);
        $display("test busy refusal done");
        // reset in mid-operation, then run again
        load_all(24'habcdef, 15'h0033, 3'h7);
        go <= 1'b1;
        zv <= 5'h14;
        @(posedge clk_sys_i);
        go <= 1'b0;
        repeat (5) @(posedge clk_sys_i);
        rstn_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        #1;
        check_reset();
        @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        @(posedge clk_sys_i);
        run_op(1'b1, 5'h05, 1'b0, 1'b0);
        $display("test mid reset done");
        finish_test();
    end
endmodule : tb_accumulator_right_shifter
